// File: core/hbridge_pkg.sv
// Shared types and constants for the H-bridge decay and blanking controller.
package hbridge_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic upper_switch_a;
    logic upper_switch_b;
    logic lower_switch_a;
    logic lower_switch_b;
  } gate_t;

  typedef struct packed {
    logic pwm_input_a;
    logic pwm_input_b;
    logic short_brake_input;
  } ctrl_t;

  typedef enum {
    DECAY_OFF,
    DECAY_CHARGE,
    DECAY_SLOW,
    DECAY_FAST
  } decay_t;

  // ----------------------------------------------------------------
  // Timing in reference oscillator cycles
  // ----------------------------------------------------------------
  localparam int unsigned CHOP_DIV      = 8;
  localparam int unsigned FORCED_CHARGE = 3;
  localparam int unsigned MIX_PERCENT_X10 = 375;
  localparam int unsigned FAST_START    = CHOP_DIV - (CHOP_DIV * MIX_PERCENT_X10) / 1000;
  localparam int unsigned DEAD_BAND     = 4;
  localparam int unsigned TRIP_MIN      = 5;
  localparam int unsigned TRIP_MAX      = 8;
  localparam int unsigned BLANK_LEN     = FORCED_CHARGE;

  // ----------------------------------------------------------------
  // Mode select codes that choose stepping-motor operation
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_STEP_S = 3'h7;
  localparam logic [2:0] MODE_STEP_L = 3'h5;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [2:0] PHASE_RESET = 3'h0;
  localparam logic [3:0] GATE_RESET  = 4'h0;

endpackage

// File: core/hbridge_decay_blank_ctrl.sv
// One H-bridge: decay sequencing, switch patterns, blanking and over-current trip.
`timescale 1ns/1ps

// Notes on behaviour
// - Forward: charge Ua+Lb, slow both lowers, fast Ub+La.
// - Reverse: charge Ub+La, slow both lowers, fast Ua+Lb.
// - Mixed decay runs charge, then slow if current is reached after forced charge, then fast each chopping period.
// - Over-current ignored for four oscillator cycles after switching.
// - Outputs turn off no sooner than five cycles after sustained over-current.
// - Outputs turn off no later than eight cycles after sustained over-current.
// - Trip may be missed when over-current coincides badly with switching.
// - Analog blanking is fixed internally; nothing here adjusts it.
// - DC-mode digital blank window is counted in oscillator periods.
// - Stepping mode forces the digital blank window to zero.
// - DC mode starts a blank window on any PWM or brake input change.
// - DC mode starts a blank window when each charge phase begins.
// - DC operation regulates with 37.5 percent mixed decay.
// - First three cycles of each period are forced charge; DC-mode blank covers cycles two to four.
// - Current reached during forced charge goes straight to fast decay.
// - Chopping period is eight oscillator cycles.
module hbridge_decay_blank_ctrl #(
  parameter int unsigned PERIOD = hbridge_pkg::CHOP_DIV
) (
  input  wire logic                CLK_I,
  input  wire logic                RESET_I,
  input  wire hbridge_pkg::ctrl_t  CTRL_I,
  input  wire logic [2:0]          MODE_I,
  input  wire logic                CURRENT_REACHED_I,
  input  wire logic                OVERCURRENT_I,
  output hbridge_pkg::gate_t       GATE_O,
  output logic                     BLANK_O,
  output logic                     SHUTDOWN_O
);

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic hbridge_pkg::gate_t pattern(input hbridge_pkg::decay_t d,
                                                 input logic fwd);
    hbridge_pkg::gate_t g;
    g = hbridge_pkg::gate_t'(hbridge_pkg::GATE_RESET);
    case (d)
      hbridge_pkg::DECAY_CHARGE: begin
        g.upper_switch_a = fwd;
        g.lower_switch_b = fwd;
        g.upper_switch_b = !fwd;
        g.lower_switch_a = !fwd;
      end
      hbridge_pkg::DECAY_SLOW: begin
        g.lower_switch_a = 1'b1;
        g.lower_switch_b = 1'b1;
      end
      hbridge_pkg::DECAY_FAST: begin
        g.upper_switch_b = fwd;
        g.lower_switch_a = fwd;
        g.upper_switch_a = !fwd;
        g.lower_switch_b = !fwd;
      end
      default: g = hbridge_pkg::gate_t'(hbridge_pkg::GATE_RESET);
    endcase
    return g;
  endfunction

  function automatic logic is_stepper(input logic [2:0] m);
    return (m == hbridge_pkg::MODE_STEP_S) || (m == hbridge_pkg::MODE_STEP_L);
  endfunction

  // ----------------------------------------------------------------
  // Chopping period sequencer
  // ----------------------------------------------------------------
  logic [2:0]          phase;
  logic [2:0]          next_phase;
  logic                reached;
  logic                next_reached;
  logic                early;
  logic                next_early;
  hbridge_pkg::decay_t decay;
  logic                stepper;
  logic                forward;

  assign stepper = is_stepper(MODE_I);
  assign forward = CTRL_I.pwm_input_a;

  always_comb begin
    next_phase   = (phase == 3'(PERIOD - 1)) ? hbridge_pkg::PHASE_RESET : phase + 3'h1;
    next_reached = (phase == 3'(PERIOD - 1)) ? 1'b0 : (reached | CURRENT_REACHED_I);
    next_early   = early;
    if (phase == 3'(PERIOD - 1)) begin
      next_early = 1'b0;
    end else if (phase == 3'(hbridge_pkg::FORCED_CHARGE - 1)) begin
      next_early = reached | CURRENT_REACHED_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      phase   <= hbridge_pkg::PHASE_RESET;
      reached <= 1'b0;
      early   <= 1'b0;
    end else begin
      phase   <= next_phase;
      reached <= next_reached;
      early   <= next_early;
    end
  end

  always_comb begin
    if (CTRL_I.short_brake_input || (CTRL_I.pwm_input_a && CTRL_I.pwm_input_b)) begin
      decay = hbridge_pkg::DECAY_SLOW;
    end else if (!(CTRL_I.pwm_input_a ^ CTRL_I.pwm_input_b)) begin
      decay = hbridge_pkg::DECAY_OFF;
    // forced charge in the first cycles; mixed decay thereafter.
    end else if (phase < 3'(hbridge_pkg::FORCED_CHARGE)) begin
      decay = hbridge_pkg::DECAY_CHARGE;
    end else if (phase >= 3'(hbridge_pkg::FAST_START)) begin
      decay = hbridge_pkg::DECAY_FAST;
    end else if (early) begin
      decay = hbridge_pkg::DECAY_FAST;
    end else if (reached) begin
      decay = hbridge_pkg::DECAY_SLOW;
    end else begin
      decay = hbridge_pkg::DECAY_CHARGE;
    end
  end

  // ----------------------------------------------------------------
  // Gate drive and over-current trip
  // ----------------------------------------------------------------
  hbridge_pkg::gate_t gate;
  hbridge_pkg::gate_t next_gate;
  hbridge_pkg::gate_t target;
  logic [2:0]         dead;
  logic [2:0]         next_dead;
  logic [2:0]         oc_cnt;
  logic [2:0]         next_oc_cnt;
  logic               shutdown;
  logic               next_shutdown;

  always_comb begin
    // count sustained over-current only outside the dead band.
    next_oc_cnt = (OVERCURRENT_I && dead == 3'h0) ? oc_cnt + 3'h1 : 3'h0;
    // trip at the fifth cycle; well inside eight; dead band may defer it.
    next_shutdown = shutdown ||
                    (OVERCURRENT_I && dead == 3'h0 &&
                     oc_cnt == 3'(hbridge_pkg::TRIP_MIN - 1));
    target = next_shutdown ? hbridge_pkg::gate_t'(hbridge_pkg::GATE_RESET)
                           : pattern(decay, forward);
    // switches turning off go one cycle ahead of any that turn on.
    if ((gate & ~target) != hbridge_pkg::gate_t'(hbridge_pkg::GATE_RESET)) begin
      next_gate = gate & target;
    end else begin
      next_gate = target;
    end
    // restart the dead band at every switching edge.
    if (next_gate != gate) begin
      next_dead = 3'(hbridge_pkg::DEAD_BAND);
    end else begin
      next_dead = (dead != 3'h0) ? dead - 3'h1 : 3'h0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      gate     <= hbridge_pkg::gate_t'(hbridge_pkg::GATE_RESET);
      dead     <= 3'h0;
      oc_cnt   <= 3'h0;
      shutdown <= 1'b0;
    end else begin
      gate     <= next_gate;
      dead     <= next_dead;
      oc_cnt   <= next_oc_cnt;
      shutdown <= next_shutdown;
    end
  end

  assign GATE_O     = gate;
  assign SHUTDOWN_O = shutdown;

  // ----------------------------------------------------------------
  // Digital blank window
  // ----------------------------------------------------------------
  hbridge_pkg::ctrl_t ctrl_prev;
  logic [1:0]         blank_cnt;
  logic [1:0]         next_blank_cnt;
  logic               charge_start;

  // a charge phase starts at the head of each driven period.
  assign charge_start = (phase == hbridge_pkg::PHASE_RESET) &&
                        (decay == hbridge_pkg::DECAY_CHARGE);

  always_comb begin
    // stepping mode holds the window at zero; analog blanking applies.
    if (stepper) begin
      next_blank_cnt = 2'h0;
    // input change or charge start reloads; length in oscillator cycles.
    end else if (CTRL_I != ctrl_prev || charge_start) begin
      next_blank_cnt = 2'(hbridge_pkg::BLANK_LEN);
    end else begin
      next_blank_cnt = (blank_cnt != 2'h0) ? blank_cnt - 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ctrl_prev <= hbridge_pkg::ctrl_t'(3'h0);
      blank_cnt <= 2'h0;
    end else begin
      ctrl_prev <= CTRL_I;
      blank_cnt <= next_blank_cnt;
    end
  end

  // analog window untouched.
  // The fixed analog blank lives outside this logic, so no input here can stretch it.
  assign BLANK_O = (blank_cnt != 2'h0);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Consecutive over-current count seen at the pin, for the trip bounds.
  logic [3:0] oc_run;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      oc_run <= 4'h0;
    end else begin
      oc_run <= OVERCURRENT_I ? ((oc_run == 4'hF) ? oc_run : oc_run + 4'h1) : 4'h0;
    end
  end

  // a switching edge inside the run restarts the count, so only clean runs bind.
  sequence s_clean_oc;
    (OVERCURRENT_I && dead == 3'h0 && oc_cnt == 3'h0 && !shutdown) ##1
    (OVERCURRENT_I && dead == 3'h0)[*4];
  endsequence

  a_no_shoot_through: assert property (
    !(gate.upper_switch_a && gate.lower_switch_a) &&
    !(gate.upper_switch_b && gate.lower_switch_b) &&
    !($past(gate.upper_switch_a) && gate.lower_switch_a) &&
    !($past(gate.lower_switch_a) && gate.upper_switch_a))
    else $error("half-bridge switches overlap");
  a_fwd_charge: assert property (
    (decay == hbridge_pkg::DECAY_CHARGE && forward && !next_shutdown && gate == target)
    |=> GATE_O == 4'h9)
    else $error("forward charge pattern wrong");
  a_rev_fast: assert property (
    (decay == hbridge_pkg::DECAY_FAST && !forward && !next_shutdown && gate == target)
    |=> GATE_O == 4'h9)
    else $error("reverse fast pattern wrong");
  a_forced_charge: assert property (
    (phase < 3'h3 && CTRL_I.pwm_input_a != CTRL_I.pwm_input_b && !CTRL_I.short_brake_input)
    |-> decay == hbridge_pkg::DECAY_CHARGE)
    else $error("charge not held in forced cycles");
  a_period_wrap: assert property (
    phase == 3'h7 |=> phase == 3'h0 ##7 phase == 3'h7)
    else $error("chopping period not eight cycles");
  a_decay_order: assert property (
    (decay == hbridge_pkg::DECAY_FAST && phase != 3'h0 && $stable(CTRL_I)) ##1 $stable(CTRL_I)
    |-> decay != hbridge_pkg::DECAY_SLOW || phase == 3'h0)
    else $error("slow decay after fast in one period");
  a_blank_stepper: assert property (
    stepper |=> !BLANK_O)
    else $error("digital blank active in stepping mode");
  a_blank_input: assert property (
    (!stepper && CTRL_I != $past(CTRL_I)) |=> BLANK_O[*3])
    else $error("blank window missing after input change");
  a_trip_min: assert property (
    $rose(shutdown) |-> oc_run >= 4'h5)
    else $error("shutdown before five cycles");
  a_trip_max: assert property (
    s_clean_oc |-> ##[0:3] shutdown)
    else $error("shutdown later than eight cycles");
  a_gate_off: assert property (
    shutdown |-> GATE_O == 4'h0)
    else $error("gates on after shutdown");

endmodule

// File: tb/hbridge_ctrl_partner.sv
// Controller model that drives the PWM, brake and mode select pins.
`timescale 1ns/1ps
module hbridge_ctrl_partner (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire hbridge_pkg::ctrl_t cmd_ctrl_i,
  input  wire logic [2:0]         cmd_mode_i,
  output hbridge_pkg::ctrl_t      ctrl_o,
  output logic [2:0]              mode_o
);
  initial begin
    ctrl_o = '0;
    mode_o = 3'h4;
  end
  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // mode held stable
  // Mode is taken only in reset, so it never moves while the bridge runs.
  always @(posedge clk_i) begin
    ctrl_o <= cmd_ctrl_i;
    if (rst_i) begin
      mode_o <= cmd_mode_i;
    end
  end
endmodule

// File: tb/hbridge_decay_blank_ctrl_tb.sv
// Self-checking bench with a reference model of the bridge controller.
`timescale 1ns/1ps
module hbridge_decay_blank_ctrl_tb;
  logic               clk;
  logic               rst;
  logic               oc;
  logic               reached;
  logic [2:0]         cmd_mode;
  hbridge_pkg::ctrl_t cmd;
  hbridge_pkg::ctrl_t ctrl;
  hbridge_pkg::ctrl_t prev;
  logic [2:0]         mode;
  hbridge_pkg::gate_t gate;
  logic               blank;
  logic               sdn;
  int                 err_total = 0;
  int                 samples_checked = 0;
  int                 ph;
  int                 mb;
  int                 n;
  int                 rnd;
  int                 skip;
  logic [3:0]         mg;
  logic [3:0]         tgt;
  logic               early;
  logic               rch;
  logic               msd;
  logic               chk_on = 1'b1;
  logic               chk_blk = 1'b1;
  logic [2:0]         modes [4] = '{3'h4, hbridge_pkg::MODE_STEP_S, hbridge_pkg::MODE_STEP_L, 3'h2};

  hbridge_decay_blank_ctrl uut (.CLK_I(clk), .RESET_I(rst), .CTRL_I(ctrl), .MODE_I(mode),
    .CURRENT_REACHED_I(reached), .OVERCURRENT_I(oc), .GATE_O(gate), .BLANK_O(blank),
    .SHUTDOWN_O(sdn));
  hbridge_ctrl_partner ctl (.clk_i(clk), .rst_i(rst), .cmd_ctrl_i(cmd), .cmd_mode_i(cmd_mode),
    .ctrl_o(ctrl), .mode_o(mode));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Reference model, ctrl bit 2 is input a, bit 1 input b, bit 0 brake
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      ph = 0;
      mg = 4'h0;
      mb = 0;
      early = 1'b0;
      rch = 1'b0;
      msd = 1'b0;
      skip = 1;
    end else begin
      if (ctrl[0] || (ctrl[2] && ctrl[1])) tgt = 4'h3;
      else if (!ctrl[2] && !ctrl[1]) tgt = 4'h0;
      else if (ph < hbridge_pkg::FORCED_CHARGE || (ph < hbridge_pkg::FAST_START && !early
               && !rch)) tgt = ctrl[2] ? 4'h9 : 4'h6;
      else if (ph < hbridge_pkg::FAST_START && !early) tgt = 4'h3;
      else tgt = ctrl[2] ? 4'h6 : 4'h9;
      early = (ph == 0) ? reached : (ph < hbridge_pkg::FORCED_CHARGE) ? early | reached : early;
      // Reach is remembered for the rest of the period and forgotten at its last cycle.
      rch = (ph == hbridge_pkg::CHOP_DIV - 1) ? 1'b0 : rch | reached;
      if (mode == hbridge_pkg::MODE_STEP_S || mode == hbridge_pkg::MODE_STEP_L) mb = 0;
      else if (ctrl !== prev || (ph == 0 && (ctrl[2] ^ ctrl[1]) && !ctrl[0]))
        mb = hbridge_pkg::BLANK_LEN;
      else if (mb > 0) mb--;
      if (msd) mg = 4'h0;
      else if ((mg & ~tgt) != 4'h0) mg = mg & tgt;
      else mg = tgt;
      ph = (ph + 1) % hbridge_pkg::CHOP_DIV;
      if (skip > 0) skip--;
    end
    prev = ctrl;
  end

  always @(negedge clk) begin
    if (!rst && skip == 0 && chk_on) begin
      chk(gate, mg);
      chk({3'h0, (gate[3] & gate[1]) | (gate[2] & gate[0])}, 4'h0);
      if (chk_blk) chk({3'h0, blank}, {3'h0, mb != 0});
      chk({3'h0, sdn}, {3'h0, msd});
    end
  end

  task automatic do_reset(input logic [2:0] m);
    @(posedge clk);
    cmd <= '0;
    cmd_mode <= m;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic run(input int cycles, input logic rnd_on, input logic [2:0] c);
    repeat (cycles) begin
      @(posedge clk);
      if (!rnd_on) cmd <= c;
      else if ($urandom % 6 == 0) cmd <= 3'($urandom);
      reached <= rnd_on && ($urandom % 2 == 1);
    end
  endtask

  initial begin
    rst = 1'b1;
    oc = 1'b0;
    reached = 1'b0;
    cmd = '0;
    cmd_mode = 3'h4;
    rnd = $urandom(31972);
    foreach (modes[i]) begin
      do_reset(modes[i]);
      run(24, 1'b0, 3'b100);
      run(24, 1'b0, 3'b010);
      run(8, 1'b0, 3'b001);
      run(8, 1'b0, 3'b000);
      run(8, 1'b0, 3'b110);
      run(200, 1'b1, 3'b000);
    end
    do_reset(3'h4);
    run(12, 1'b0, 3'b001);
    chk_on = 1'b0;
    oc <= 1'b1;
    repeat (4) @(posedge clk);
    oc <= 1'b0;
    repeat (7) @(posedge clk);
    @(negedge clk);
    chk({3'h0, sdn}, 4'h0);
    @(posedge clk);
    oc <= 1'b1;
    n = 0;
    while (sdn !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    // The count holds one extra falling edge ahead of the first sampling edge.
    chk({3'h0, n > hbridge_pkg::TRIP_MIN && n <= hbridge_pkg::TRIP_MAX + 1}, 4'h1);
    chk_blk = 1'b0;
    msd = 1'b1;
    @(negedge clk);
    chk_on = 1'b1;
    run(30, 1'b1, 3'b000);
    finish_test();
  end

  initial begin
    #(100 * 5000);
    err_total++;
    finish_test();
  end
endmodule
